// ---- aif_pkg.sv ----
package aif_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W      = 6;
  localparam logic [5:0]  STATUS_ADDR = 6'h00;
  localparam logic [5:0]  IFMODE_ADDR = 6'h02;
  localparam logic [5:0]  CHECK_ADDR  = 6'h03;
  localparam logic [5:0]  RESULT_ADDR = 6'h04;
  localparam logic [5:0]  GPIO_ADDR   = 6'h06;
  localparam logic [5:0]  SETUP_ADDR  = 6'h20;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] IFMODE_RST  = 16'h0000;
  localparam logic [15:0] GPIO_RST    = 16'h0800;
  localparam logic [15:0] SETUP_RST   = 16'h0000;
  localparam logic [23:0] CHECK_RST   = 24'h000000;
  localparam logic [23:0] RESULT_RST  = 24'h000000;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int          IFM_WL_BIT   = 0;
  localparam int          IFM_RSV_BIT  = 1;
  localparam int          IFM_PROT_LSB = 2;
  localparam int          IFM_CHK_BIT  = 5;
  localparam int          IFM_STAT_BIT = 6;
  localparam logic [1:0]  PROT_OFF     = 2'h0;
  localparam logic [1:0]  PROT_XOR     = 2'h1;
  localparam logic [1:0]  PROT_CRC     = 2'h2;
  localparam logic [15:0] GPIO_RSV_MSK = 16'he000;
  localparam int          SETUP_POL_BIT = 12;
  localparam int          STAT_RDYN_BIT = 7;
  localparam int          STAT_ERR_BIT  = 3;
  localparam logic [24:0] ROUND_HALF    = 25'h0000080;
  localparam logic [23:0] SIGN_FLIP     = 24'h800000;
  localparam logic [2:0]  BYTES_16      = 3'h2;
  localparam logic [2:0]  BYTES_24      = 3'h3;
  localparam logic [2:0]  BYTES_8       = 3'h1;

  typedef enum logic {
    RD_IDLE,
    RD_BUSY
  } aif_rd_state_type;

endpackage

// ---- aif_fmt_if.sv ----
interface aif_fmt_if;
  logic [23:0] raw;
  logic        unipolar;
  logic        short_word_select;
  logic [23:0] coded;

  modport src (output raw, output unipolar, output short_word_select, input coded);
  modport fmt (input raw, input unipolar, input short_word_select, output coded);
endinterface

// ---- aif_result_fmt.sv ----
module aif_result_fmt (
  aif_fmt_if.fmt f
);

  logic [23:0] code;
  logic [24:0] sum;
  logic [15:0] short_word;

  always_comb begin
    // Converter delivers two's complement; negative input clamps in unipolar
    if (f.unipolar) begin
      code = f.raw[23] ? 24'h000000 : {f.raw[22:0], 1'b0};
    end else begin
      code = f.raw ^ aif_pkg::SIGN_FLIP;
    end
    // Rounding saturates so full scale never wraps to zero
    sum        = {1'b0, code} + aif_pkg::ROUND_HALF;
    short_word = sum[24] ? 16'hffff : sum[23:8];
    f.coded    = f.short_word_select ? {8'h00, short_word} : code;
  end

endmodule

// ---- aif_result_regs.sv ----
// Function
// - Two-bit protection select, 00 unprotected
// - Protection adds exactly one checksum byte
// - Select 01: XOR on reads, CRC writes
// - Select 10: CRC on reads and writes
// - Short-word bit picks 24 or 16 bits
// - Mode write keeps old result, next changes
// - Checksum is XOR of covered registers
// - Checksum reads zero while checking disabled
// - Offset binary, or unipolar by polarity select
// - Result read drives ready high
// - Repeated result reads allowed, ready stays high
// - No result update during result read
// - Status appended after result when enabled
// - GPIO configuration top three bits read-only zero
// - Interface mode bit 1 read-only zero
// - Covered change sets error, disable clears
// - Mode, result, status not checksum covered
module aif_result_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_ce,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_start,
  input  wire logic                        i_rd_end,
  input  wire logic [aif_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [23:0]                 i_wdata,
  input  wire logic                        i_conv_valid,
  input  wire logic [23:0]                 i_conv_data,
  output logic      [31:0]                 o_rd_data,
  output logic      [2:0]                  o_rd_bytes,
  output logic      [7:0]                  o_rd_xor,
  output logic      [1:0]                  o_prot_sel,
  output logic                             o_extra_byte,
  output logic                             o_ready_n,
  output logic                             o_reg_error
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    aif_pkg::aif_rd_state_type rd_st;
    logic [15:0]               ifmode;
    logic [15:0]               gpio;
    logic [15:0]               setup;
    logic [23:0]               result;
    logic                      res16;
    logic                      ready_n;
    logic                      pend;
    logic [23:0]               pend_val;
    logic                      pend16;
    logic [23:0]               check;
    logic [23:0]               golden;
    logic                      reg_err;
    logic [31:0]               rd_data;
    logic [2:0]                rd_bytes;
    logic [7:0]                rd_xor;
    logic [1:0]                prot;
    logic                      extra;
  } aif_state_type;

  aif_state_type q;
  aif_state_type d;
  aif_fmt_if     fmt_bus ();

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_result(input logic [aif_pkg::ADDR_W-1:0] a);
    is_result = (a == aif_pkg::RESULT_ADDR);
  endfunction

  // Mode, result and status stay outside the sum so that normal reads and
  // mode changes never trip the integrity flag
  function automatic logic [23:0] cover_xor(input logic [15:0] g, input logic [15:0] s);
    cover_xor = {8'h00, g} ^ {8'h00, s};
  endfunction

  function automatic logic [7:0] byte_xor(input logic [aif_pkg::ADDR_W-1:0] a,
                                          input logic [31:0]                data,
                                          input logic [2:0]                 n);
    logic [7:0] acc;
    acc = {2'b00, a};
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) begin
        acc = acc ^ data[8*i +: 8];
      end
    end
    byte_xor = acc;
  endfunction

  assign fmt_bus.raw      = i_conv_data;
  assign fmt_bus.unipolar = q.setup[aif_pkg::SETUP_POL_BIT];
  assign fmt_bus.short_word_select = q.ifmode[aif_pkg::IFM_WL_BIT];

  aif_result_fmt u_fmt (
    .f (fmt_bus.fmt)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic        busy;
  logic        res_rd;
  logic [7:0]  stat_byte;
  logic [31:0] mux_data;
  logic [2:0]  mux_bytes;
  logic [23:0] sum_now;

  always_comb begin
    d         = q;
    res_rd    = i_rd_start && is_result(i_addr);
    busy      = (q.rd_st == aif_pkg::RD_BUSY) || res_rd;
    stat_byte = 8'h00;
    stat_byte[aif_pkg::STAT_RDYN_BIT] = q.ready_n;
    stat_byte[aif_pkg::STAT_ERR_BIT]  = q.reg_err;
    mux_data  = 32'h00000000;
    mux_bytes = aif_pkg::BYTES_8;

    // Register writes
    if (i_wr_en) begin
      case (i_addr)
        aif_pkg::IFMODE_ADDR: begin
          d.ifmode = i_wdata[15:0];
          d.ifmode[aif_pkg::IFM_RSV_BIT] = 1'b0;
        end
        aif_pkg::GPIO_ADDR: begin
          d.gpio = i_wdata[15:0] & ~aif_pkg::GPIO_RSV_MSK;
        end
        aif_pkg::SETUP_ADDR: begin
          d.setup = i_wdata[15:0];
        end
        default: begin
          d.ifmode = q.ifmode;
        end
      endcase
    end

    // Protection select drives framing of the serial engine
    d.prot  = d.ifmode[aif_pkg::IFM_PROT_LSB +: 2];
    d.extra = (d.prot != aif_pkg::PROT_OFF);

    // Integrity checker
    sum_now = cover_xor(d.gpio, d.setup);
    if (d.ifmode[aif_pkg::IFM_CHK_BIT]) begin
      d.check = sum_now;
      if (!q.ifmode[aif_pkg::IFM_CHK_BIT]) begin
        d.golden = sum_now;
      end else if (sum_now != q.golden) begin
        d.reg_err = 1'b1;
      end
    end else begin
      d.check   = aif_pkg::CHECK_RST;
      d.reg_err = 1'b0;
    end

    // Read capture
    case (i_addr)
      aif_pkg::STATUS_ADDR: begin
        mux_data  = {24'h000000, stat_byte};
      end
      aif_pkg::IFMODE_ADDR: begin
        mux_data  = {16'h0000, q.ifmode};
        mux_bytes = aif_pkg::BYTES_16;
      end
      aif_pkg::CHECK_ADDR: begin
        mux_data  = {8'h00, q.check};
        mux_bytes = aif_pkg::BYTES_24;
      end
      aif_pkg::RESULT_ADDR: begin
        mux_bytes = q.res16 ? aif_pkg::BYTES_16 : aif_pkg::BYTES_24;
        mux_data  = {8'h00, q.result};
        if (q.ifmode[aif_pkg::IFM_STAT_BIT]) begin
          mux_data  = q.res16 ? {8'h00, q.result[15:0], stat_byte} : {q.result, stat_byte};
          mux_bytes = mux_bytes + 3'h1;
        end
      end
      aif_pkg::GPIO_ADDR: begin
        mux_data  = {16'h0000, q.gpio};
        mux_bytes = aif_pkg::BYTES_16;
      end
      aif_pkg::SETUP_ADDR: begin
        mux_data  = {16'h0000, q.setup};
        mux_bytes = aif_pkg::BYTES_16;
      end
      default: begin
        mux_data  = 32'h00000000;
      end
    endcase

    if (i_rd_start) begin
      d.rd_data  = mux_data;
      d.rd_bytes = mux_bytes;
      // Only the XOR mode is built here; CRC belongs to the serial engine
      d.rd_xor   = (q.prot == aif_pkg::PROT_XOR) ? byte_xor(i_addr, mux_data, mux_bytes) : 8'h00;
    end

    // Read engine
    case (q.rd_st)
      aif_pkg::RD_IDLE: begin
        if (res_rd) begin
          d.rd_st = aif_pkg::RD_BUSY;
        end
      end
      aif_pkg::RD_BUSY: begin
        // A new result read in the same cycle as the end keeps the hold
        if (i_rd_end && !res_rd) begin
          d.rd_st = aif_pkg::RD_IDLE;
        end
      end
      default: begin
        d.rd_st = aif_pkg::RD_IDLE;
      end
    endcase

    // Result update; length follows the mode at conversion time
    if (i_conv_valid) begin
      if (busy) begin
        d.pend     = 1'b1;
        d.pend_val = fmt_bus.coded;
        d.pend16   = q.ifmode[aif_pkg::IFM_WL_BIT];
      end else begin
        d.result  = fmt_bus.coded;
        d.res16   = q.ifmode[aif_pkg::IFM_WL_BIT];
        d.ready_n = 1'b0;
        d.pend    = 1'b0;
      end
    end else if (q.pend && !busy) begin
      d.result  = q.pend_val;
      d.res16   = q.pend16;
      d.ready_n = 1'b0;
      d.pend    = 1'b0;
    end

    // Any result read forces ready high until the next result is committed
    if (res_rd) begin
      d.ready_n = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q          <= '0;
      q.rd_st    <= aif_pkg::RD_IDLE;
      q.ifmode   <= aif_pkg::IFMODE_RST;
      q.gpio     <= aif_pkg::GPIO_RST;
      q.setup    <= aif_pkg::SETUP_RST;
      q.result   <= aif_pkg::RESULT_RST;
      q.check    <= aif_pkg::CHECK_RST;
      q.ready_n  <= 1'b1;
      q.rd_bytes <= aif_pkg::BYTES_8;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rd_data    = q.rd_data;
  assign o_rd_bytes   = q.rd_bytes;
  assign o_rd_xor     = q.rd_xor;
  assign o_prot_sel   = q.prot;
  assign o_extra_byte = q.extra;
  assign o_ready_n    = q.ready_n;
  assign o_reg_error  = q.reg_err;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence result_read_s;
    i_ce && i_rd_start && (i_addr == aif_pkg::RESULT_ADDR);
  endsequence

  sequence mode_write_s;
    i_ce && i_wr_en && (i_addr == aif_pkg::IFMODE_ADDR);
  endsequence

  mode_rsvd_a: assert property (mode_write_s |=> !q.ifmode[1])
    else $error("interface mode reserved bit set");

  gpio_rsvd_a: assert property (i_ce && i_wr_en && (i_addr == aif_pkg::GPIO_ADDR)
                                |=> (q.gpio[15:13] == 3'h0))
    else $error("gpio reserved bits set");

  frame_byte_a: assert property (mode_write_s ##1 1'b1
                                 |-> o_extra_byte == ($past(i_wdata[3:2]) != 2'h0))
    else $error("extra byte does not follow protection select");

  check_zero_a: assert property (!q.ifmode[5] |-> q.check == 24'h0)
    else $error("checksum not zero while disabled");

  check_value_a: assert property (q.ifmode[5] |-> q.check == ({8'h00, q.gpio} ^ {8'h00, q.setup}))
    else $error("checksum does not match covered registers");

  ready_read_a: assert property (result_read_s |=> o_ready_n ##1 (o_ready_n || $past(i_conv_valid)
                                 || $past(q.pend)))
    else $error("ready not high after result read");

  hold_off_a: assert property (i_ce && (q.rd_st == aif_pkg::RD_BUSY) && !i_rd_end |=> $stable(q.result))
    else $error("result changed during result read");

  append_a: assert property (result_read_s and (q.ifmode[6] && !q.res16) |=> o_rd_bytes == 3'h4)
    else $error("status not appended to result");

  error_clear_a: assert property (mode_write_s and (!i_wdata[5]) |=> !o_reg_error)
    else $error("integrity error not cleared");

  short_word_a: assert property (i_ce && i_conv_valid && !busy && q.ifmode[0]
                                 |=> q.res16 && (q.result[23:16] == 8'h00))
    else $error("short result not sixteen bits");

  sequence pend_commit_s;
    i_ce && q.pend && !busy && !i_conv_valid;
  endsequence

  commit_after_a: assert property (pend_commit_s
                                   |=> !o_ready_n && (q.result == $past(q.pend_val)))
    else $error("pending result not committed after read");

  reread_ready_a: assert property (result_read_s and (o_ready_n) |=> o_ready_n)
    else $error("ready fell on repeated result read");

  xor_zero_a: assert property (i_ce && i_rd_start && (q.prot != aif_pkg::PROT_XOR)
                               |=> o_rd_xor == 8'h00)
    else $error("xor byte present outside xor mode");

  prot_copy_a: assert property (o_prot_sel == q.ifmode[3:2])
    else $error("protection select does not follow mode");

  check_read_a: assert property (i_ce && i_rd_start && (i_addr == aif_pkg::CHECK_ADDR)
                                 |=> o_rd_data == {8'h00, $past(q.check)})
    else $error("checksum read value wrong");

  append_short_a: assert property (result_read_s and (q.ifmode[6] && q.res16) |=> o_rd_bytes == 3'h3)
    else $error("status not appended to short result");

  old_length_a: assert property (mode_write_s and (!i_conv_valid && !q.pend) |=> $stable(q.res16))
    else $error("mode write changed stored result length");

endmodule

// ---- aif_host_model.sv ----
module aif_host_model (
  input  wire logic        i_clk,
  input  wire logic [2:0]  i_rd_bytes,
  input  wire logic        i_extra_byte,
  output logic             o_wr_en,
  output logic             o_rd_start,
  output logic             o_rd_end,
  output logic [5:0]       o_addr,
  output logic [23:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int frame_len;
  initial begin
    o_wr_en    = 1'b0;
    o_rd_start = 1'b0;
    o_rd_end   = 1'b0;
    o_addr     = 6'h3f;
    o_wdata    = 24'h000000;
    frame_len  = 0;
  end
  // ****************************************
  // Transfers
  // ****************************************
  // Released lines show inverted values so a stale capture cannot pass
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, input logic hold);
    @(negedge i_clk);
    o_rd_start = 1'b1;
    o_addr     = a;
    @(negedge i_clk);
    o_rd_start = 1'b0;
    o_addr     = ~a;
    frame_len  = 1 + int'(i_rd_bytes) + int'(i_extra_byte);
    if (!hold) begin
      end_frame();
    end
  endtask
  task automatic end_frame();
    o_rd_end = 1'b1;
    @(negedge i_clk);
    o_rd_end = 1'b0;
  endtask
endmodule

// ---- adc_iface_result_regs_tb_top.sv ----
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("wrong value t=%0t %s", $time, m); end end
module adc_iface_result_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_sys_rst, wr_en, rd_start, rd_end, cv, extra, ready_n, reg_error, ce;
  logic [5:0]  addr;
  logic [23:0] wdata, cd;
  logic [31:0] rd_data;
  logic [2:0]  rd_bytes;
  logic [7:0]  rd_xor;
  logic [1:0]  prot;
  int          error_cnt, checked;
  localparam logic [5:0] MA = aif_pkg::IFMODE_ADDR;
  localparam logic [5:0] GA = aif_pkg::GPIO_ADDR;
  localparam logic [5:0] CA = aif_pkg::CHECK_ADDR;
  localparam logic [5:0] RA = aif_pkg::RESULT_ADDR;
  localparam logic [5:0] SA = aif_pkg::SETUP_ADDR;
  always #2.5 i_clk = ~i_clk;
  aif_result_regs dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_wr_en(wr_en), .i_rd_start(rd_start),
    .i_rd_end(rd_end), .i_addr(addr), .i_wdata(wdata), .i_conv_valid(cv), .i_conv_data(cd), .o_rd_data(rd_data),
    .o_rd_bytes(rd_bytes), .o_rd_xor(rd_xor), .o_prot_sel(prot), .o_extra_byte(extra), .o_ready_n(ready_n),
    .o_reg_error(reg_error));
  aif_host_model host (.i_clk(i_clk), .i_rd_bytes(rd_bytes), .i_extra_byte(extra), .o_wr_en(wr_en),
    .o_rd_start(rd_start), .o_rd_end(rd_end), .o_addr(addr), .o_wdata(wdata));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string m);
    host.rd(a, 1'b0);
    `CHK(rd_data, e, m)
  endtask
  task automatic conv(input logic [23:0] d);
    @(negedge i_clk);
    cv = 1'b1;
    cd = d;
    @(negedge i_clk);
    cv = 1'b0;
    cd = ~d;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK({ready_n, prot, extra, reg_error, rd_bytes}, 8'h81, "reset outputs")
    rchk(GA, 32'h00000800, "gpio reset");
    rchk(CA, 32'h00000000, "check reset");
    rchk(RA, 32'h00000000, "result reset");
    $display("test reset done");
  endtask
  task automatic t_modes();
    host.wr(MA, 24'h000004);
    `CHK({prot, extra}, 3'h3, "xor mode")
    host.wr(MA, 24'h000008);
    `CHK({prot, extra}, 3'h5, "crc mode")
    host.wr(MA, 24'h00000c);
    `CHK({prot, extra}, 3'h7, "code 11 framed")
    host.wr(MA, 24'h000002);
    rchk(MA, 32'h00000000, "mode bit1");
    `CHK({prot, extra}, 3'h0, "mode off")
    host.wr(GA, 24'h00ffff);
    host.wr(MA, 24'h000004);
    rchk(GA, 32'h00001fff, "gpio rsvd");
    `CHK(rd_xor, 8'he6, "xor byte")
    `CHK(host.frame_len, 4, "frame len")
    host.wr(CA, 24'h123456);
    rchk(CA, 32'h00000000, "check ro");
    rchk(6'h3f, 32'h00000000, "unmapped");
    `CHK(rd_bytes, 3'h1, "unmapped bytes")
    host.wr(MA, 24'h000000);
    $display("test modes done");
  endtask
  task automatic t_check();
    host.wr(SA, 24'h000005);
    host.wr(GA, 24'h000030);
    host.wr(MA, 24'h000020);
    rchk(CA, 32'h00000035, "checksum");
    host.wr(MA, 24'h000060);
    @(negedge i_clk);
    `CHK(reg_error, 1'b0, "mode not covered")
    host.wr(GA, 24'h000031);
    @(negedge i_clk);
    `CHK(reg_error, 1'b1, "error set")
    rchk(aif_pkg::STATUS_ADDR, 32'h00000088, "status error");
    rchk(CA, 32'h00000034, "recomputed");
    host.wr(MA, 24'h000000);
    @(negedge i_clk);
    `CHK(reg_error, 1'b0, "error cleared")
    rchk(CA, 32'h00000000, "check off");
    host.wr(SA, 24'h000000);
    $display("test check done");
  endtask
  task automatic t_code();
    conv(24'h000001);
    `CHK(ready_n, 1'b0, "ready low")
    rchk(RA, 32'h00800001, "offset bin");
    `CHK({ready_n, rd_bytes}, 4'hb, "ready high")
    rchk(RA, 32'h00800001, "reread");
    `CHK(ready_n, 1'b1, "ready stays")
    rchk(aif_pkg::STATUS_ADDR, 32'h00000080, "status ready");
    host.wr(SA, 24'h001000);
    conv(24'h000010);
    rchk(RA, 32'h00000020, "unipolar");
    conv(24'hfffff0);
    rchk(RA, 32'h00000000, "unipolar neg");
    host.wr(SA, 24'h000000);
    $display("test coding done");
  endtask
  task automatic t_short_word();
    conv(24'h000100);
    host.wr(MA, 24'h000001);
    rchk(RA, 32'h00800100, "old length");
    conv(24'h1234c0);
    rchk(RA, 32'h00009235, "rounded");
    `CHK(rd_bytes, 3'h2, "short bytes")
    host.wr(MA, 24'h000000);
    $display("test length done");
  endtask
  task automatic t_hold();
    conv(24'h000003);
    host.rd(RA, 1'b1);
    conv(24'h000004);
    repeat (3) @(negedge i_clk);
    `CHK({ready_n, rd_data}, 33'h100800003, "held")
    host.end_frame();
    @(negedge i_clk);
    `CHK(ready_n, 1'b0, "commit")
    rchk(RA, 32'h00800004, "pending");
    $display("test hold done");
  endtask
  // Clock enable low must swallow both a write and a conversion
  task automatic t_freeze();
    @(negedge i_clk);
    ce = 1'b0;
    host.wr(MA, 24'h000004);
    conv(24'h000007);
    `CHK({ready_n, prot}, 3'h4, "frozen state")
    @(negedge i_clk);
    ce = 1'b1;
    rchk(RA, 32'h00800004, "frozen result");
    $display("test freeze done");
  endtask
  task automatic t_append();
    host.wr(MA, 24'h000040);
    conv(24'h000002);
    rchk(RA, 32'h80000200, "append 24");
    `CHK(rd_bytes, 3'h4, "append bytes")
    host.wr(MA, 24'h000041);
    conv(24'h000002);
    rchk(RA, 32'h00800000, "append 16");
    `CHK(rd_bytes, 3'h3, "append 16 bytes")
    host.wr(MA, 24'h000000);
    $display("test append done");
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    i_clk     = 1'b0;
    i_sys_rst = 1'b1;
    cv        = 1'b0;
    ce        = 1'b1;
    cd        = 24'h000000;
    error_cnt = 0;
    checked   = 0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_reset();
    t_modes();
    t_check();
    t_code();
    t_short_word();
    t_hold();
    t_freeze();
    t_append();
    conclude();
  end
  // Bounds the whole run so a stuck handshake cannot hang it
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    conclude();
  end
endmodule
